// *** src/dac_mode_defines.svh ***
`ifndef DAC_MODE_DEFINES_SVH
`define DAC_MODE_DEFINES_SVH
// Contract
// (RL1) Top bit 1 reads, 0 writes
// (RL2) Indices 22, 23 read-only; 23 holds identity
// (RL3) Output disable bit defaults to enabled
// (RL4) Shared pin select resets to data input
// (RL5) Bypass stereo select resets to monaural
// (RL6) Rolloff select resets to sharp
// (RL7) Infinite zero mute resets disabled
// (RL8) Soft system reset defaults to normal
// (RL9) Bitstream mode resets disabled
// (RL10) Filter bypass resets to internal filter
// (RL11) Mono defaults stereo; source defaults left
// (RL12) Oversample field resets to 64 times
// (RL13) Linear zero output on; bitstream zero off
// (RL14) Zero flags read back per channel
// (RL15) Bitstream mode: deemph field picks FIR
// (RL16) Bitstream mode: rate field picks FIR rate
// (RL17) Word: direction, 7-bit index, 8 data
// (RL18) Write after 16th clock; read after 8th
// (RL19) Reserved bits read zero, ignore writes
// (RL20) Unmapped index reads zero, changes nothing

// ****************************************
// Register indices
// ****************************************
`define IDX_ATT_LEFT    7'h10
`define IDX_ATT_RIGHT   7'h11
`define IDX_FORMAT      7'h12
`define IDX_OUT_FILTER  7'h13
`define IDX_SYS_MODE    7'h14
`define IDX_ZERO_OUT    7'h15
`define IDX_ZERO_STAT   7'h16
`define IDX_IDENTITY    7'h17

// ****************************************
// Reset values and writable masks
// ****************************************
`define RST_ATT         8'hff
`define RST_FORMAT      8'h50
`define RST_OUT_FILTER  8'h00
`define RST_SYS_MODE    8'h00
`define RST_ZERO_OUT    8'h01
`define MASK_SYS_MODE   8'h7f
`define MASK_ZERO_OUT   8'h07

// ****************************************
// Field positions
// ****************************************
`define BIT_ANALOG_DIS  4
`define BIT_PIN_SEL     3
`define BIT_BYP_STEREO  2
`define BIT_ROLLOFF     1
`define BIT_INF_MUTE    0
`define BIT_SOFT_RST    6
`define BIT_BITSTREAM   5
`define BIT_FILT_BYP    4
`define BIT_MONO        3
`define BIT_MONO_SRC    2
`define BIT_LIN_ZERO    0

// ****************************************
// Word layout
// ****************************************
`define WORD_BITS       16
`define DIR_BIT         15
`define HEAD_BITS       8
`endif

// *** src/dac_mode_pkg.sv ***
package dac_mode_pkg;
	// Oversample rate encodings
	typedef enum logic [1:0] {
		os_x64_type_val  = 2'h0,
		os_x128_type_val = 2'h1,
		os_x32_type_val  = 2'h2
	} os_rate_type;
	// Serial port phases, one-hot
	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_head = 3'h2,
		st_data = 3'h4
	} port_state_type;
endpackage

// *** src/edge_sync.sv ***
`timescale 1ns/100ps
`include "dac_mode_defines.svh"
// ****************************************
// Two-stage synchroniser with rise/fall
// ****************************************
module edge_sync (
	input  wire logic mclk_in,
	input  wire logic rstn_in,
	input  wire logic raw_in,
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);
	logic meta_reg;  // First stage, read only by next stage
	logic sync_reg;  // Second stage
	logic last_reg;  // Delayed copy for edges

	// Shift chain; edges come from stages two and three only
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= raw_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level_out = sync_reg;
	assign rise_out  = sync_reg & ~last_reg;
	assign fall_out  = ~sync_reg & last_reg;
endmodule

// *** src/word_shifter.sv ***
`timescale 1ns/100ps
`include "dac_mode_defines.svh"
// ****************************************
// Serial word shifter and bit counter
// ****************************************
module word_shifter (
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic        clear_in,
	input  wire logic        shift_in,
	input  wire logic        bit_in,
	output logic [15:0]      word_out,
	output logic [4:0]       count_out
);
	// Shift in MSB first; count saturates at a full word
	always_ff @(posedge mclk_in) begin
		if (!rstn_in || clear_in) begin
			word_out  <= 16'h0000;
			count_out <= 5'h00;
		end else if (shift_in) begin
			word_out <= {word_out[14:0], bit_in}; // RL17
			if (count_out != 5'(`WORD_BITS))
				count_out <= count_out + 5'h01;
		end
	end
endmodule

// *** src/dac_mode_regs.sv ***
`timescale 1ns/100ps
`include "dac_mode_defines.svh"
// ****************************************
// Mode register bank behind serial port
// ****************************************
module dac_mode_regs #(
	parameter logic [4:0] IDENTITY = 5'h0a  // Arbitrary value
) (
	input  wire logic                  mclk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  sel_n_in,     // Port enable, low
	input  wire logic                  sclk_in,      // Port bit clock
	input  wire logic                  sdi_in,       // Port data in
	input  wire logic                  left_zero_in,
	input  wire logic                  right_zero_in,
	output logic                       sdo_out,
	output logic                       sdo_oe_out,
	output logic [7:0]                 left_atten_out,
	output logic [7:0]                 right_atten_out,
	output logic [7:0]                 format_out,
	output logic                       analog_output_disable_out,
	output logic                       shared_pin_select_out,
	output logic                       bypass_stereo_select_out,
	output logic                       rolloff_select_out,
	output logic                       infinite_zero_mute_en_out,
	output logic                       phase_reverse_out,
	output logic [1:0]                 atten_rate_out,
	output logic                       soft_system_reset_out,
	output logic                       bitstream_mode_en_out,
	output logic                       filter_bypass_en_out,
	output logic                       mono_en_out,
	output logic                       mono_source_pick_out,
	output dac_mode_pkg::os_rate_type  oversample_rate_sel_out,
	output logic [1:0]                 deemph_rate_select_out,
	output logic [1:0]                 fir_perf_select_out,
	output logic [1:0]                 fir_rate_select_out,
	output logic                       linear_zero_output_en_out,
	output logic [1:0]                 bitstream_zero_output_out
);
	import dac_mode_pkg::*;

	// ****************************************
	// Port front end
	// ****************************************
	logic           sel_lvl;     // Synchronised enable, high in a frame
	logic           clk_rise;    // Sample point
	logic           clk_fall;    // Output change point
	logic           dat_lvl;     // Synchronised data
	logic [15:0]    word;        // Bits gathered so far
	logic [4:0]     count;       // Bits gathered so far
	logic           shift_en;    // Take a bit
	port_state_type state_reg;   // Frame phase
	port_state_type state_next;  // Next phase
	logic           dir_reg;     // Latched direction
	logic [6:0]     idx_reg;     // Latched index
	logic [7:0]     rd_shift_reg;// Read data going out
	logic           wr_done_reg; // One write per frame

	// Data is synchronised alongside the clock so both share latency.
	// The enable is inverted first: the synchroniser resets to zero,
	// which then reads as idle, so no false frame opens after reset.
	edge_sync u_sel (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.raw_in   (!sel_n_in),
		.level_out(sel_lvl),
		.rise_out (),
		.fall_out ()
	);
	edge_sync u_clk (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.raw_in   (sclk_in),
		.level_out(),
		.rise_out (clk_rise),
		.fall_out (clk_fall)
	);
	edge_sync u_dat (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.raw_in   (sdi_in),
		.level_out(dat_lvl),
		.rise_out (),
		.fall_out ()
	);

	// Bits are taken only inside an open frame
	assign shift_en = clk_rise && sel_lvl && state_reg != st_idle;

	word_shifter u_shift (
		.mclk_in  (mclk_in),
		.rstn_in  (rstn_in),
		.clear_in (state_reg == st_idle),
		.shift_in (shift_en),
		.bit_in   (dat_lvl),
		.word_out (word),
		.count_out(count)
	);

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] att_l_reg;
	logic [7:0] att_r_reg;
	logic [7:0] fmt_reg;
	logic [7:0] filt_reg;
	logic [7:0] sys_reg;
	logic [7:0] zout_reg;
	logic [1:0] zflag_reg;   // Sampled zero detectors

	// Read mux; unmapped and reserved bits give zero
	function automatic logic [7:0] read_value(input logic [6:0] idx);
		unique case (idx)
			`IDX_ATT_LEFT:   read_value = att_l_reg;
			`IDX_ATT_RIGHT:  read_value = att_r_reg;
			`IDX_FORMAT:     read_value = fmt_reg;
			`IDX_OUT_FILTER: read_value = filt_reg;
			`IDX_SYS_MODE:   read_value = sys_reg & `MASK_SYS_MODE; // RL19
			`IDX_ZERO_OUT:   read_value = zout_reg & `MASK_ZERO_OUT; // RL19
			`IDX_ZERO_STAT:  read_value = {6'h00, zflag_reg}; // RL14
			`IDX_IDENTITY:   read_value = {3'h0, IDENTITY}; // RL2
			default:         read_value = 8'h00; // RL20
		endcase
	endfunction

	// ****************************************
	// Frame sequencing
	// ****************************************
	// Enable low starts a frame; enable high always ends it
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_idle: if (sel_lvl) begin
				state_next = st_head;
			end
			st_head: if (!sel_lvl) begin
				state_next = st_idle;
			end else if (count == 5'(`HEAD_BITS)) begin
				state_next = st_data;
			end
			st_data: if (!sel_lvl) begin
				state_next = st_idle;
			end
			default: state_next = st_idle;
		endcase
	end

	// Phase register
	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			state_reg <= st_idle;
		else
			state_reg <= state_next;
	end

	// Latch direction and index after eight bits
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			dir_reg <= 1'b0;
			idx_reg <= 7'h00;
		end else if (state_reg == st_head &&
		             count == 5'(`HEAD_BITS)) begin
			dir_reg <= word[7]; // RL1
			idx_reg <= word[6:0]; // RL17
		end
	end

	// Read data loads after the eighth bit, then shifts on falls
	always_ff @(posedge mclk_in) begin
		if (!rstn_in || state_reg == st_idle) begin
			rd_shift_reg <= 8'h00;
			sdo_out      <= 1'b0;
			sdo_oe_out   <= 1'b0;
		end else if (state_reg == st_head &&
		             count == 5'(`HEAD_BITS)) begin
			// Read word is presented only for read frames
			rd_shift_reg <= read_value(word[6:0]); // RL18
			sdo_oe_out   <= word[7]; // RL1
		end else if (state_reg == st_data && clk_fall && dir_reg) begin
			sdo_out      <= rd_shift_reg[7]; // RL18
			rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
		end
	end

	// Write strobe occurs once, on the sixteenth bit
	always_ff @(posedge mclk_in) begin
		if (!rstn_in || state_reg == st_idle)
			wr_done_reg <= 1'b0;
		else if (state_reg == st_data && count == 5'(`WORD_BITS))
			wr_done_reg <= 1'b1;
	end

	// ****************************************
	// Register writes
	// ****************************************
	logic       wr_hit;     // Write completes this cycle
	logic [7:0] wr_data;    // Data byte of the word
	assign wr_hit  = state_reg == st_data && count == 5'(`WORD_BITS)
	               && !wr_done_reg && !dir_reg; // RL18
	assign wr_data = word[7:0];

	// Writable registers; 22, 23 and others fall through untouched
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			att_l_reg <= `RST_ATT;
			att_r_reg <= `RST_ATT;
			fmt_reg   <= `RST_FORMAT;
			filt_reg  <= `RST_OUT_FILTER; // RL3 RL4 RL5 RL6 RL7
			sys_reg   <= `RST_SYS_MODE; // RL8 RL9 RL10 RL11 RL12
			zout_reg  <= `RST_ZERO_OUT; // RL13
		end else if (wr_hit) begin
			unique case (idx_reg)
				`IDX_ATT_LEFT:   att_l_reg <= wr_data;
				`IDX_ATT_RIGHT:  att_r_reg <= wr_data;
				`IDX_FORMAT:     fmt_reg   <= wr_data;
				`IDX_OUT_FILTER: filt_reg  <= wr_data;
				`IDX_SYS_MODE:   sys_reg   <= wr_data & `MASK_SYS_MODE;
				`IDX_ZERO_OUT:   zout_reg  <= wr_data & `MASK_ZERO_OUT;
				default: begin
					// Status, identity and unmapped: ignored
					att_l_reg <= att_l_reg; // RL2 RL20
				end
			endcase
		end
	end

	// Zero detectors sampled each cycle for readback
	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			zflag_reg <= 2'h0;
		else
			zflag_reg <= {right_zero_in, left_zero_in}; // RL14
	end

	// ****************************************
	// Decoded controls, each from a flip-flop
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			left_atten_out            <= `RST_ATT;
			right_atten_out           <= `RST_ATT;
			format_out                <= `RST_FORMAT;
			analog_output_disable_out <= 1'b0;
			shared_pin_select_out     <= 1'b0;
			bypass_stereo_select_out  <= 1'b0;
			rolloff_select_out        <= 1'b0;
			infinite_zero_mute_en_out <= 1'b0;
			phase_reverse_out         <= 1'b0;
			atten_rate_out            <= 2'h0;
			soft_system_reset_out     <= 1'b0;
			bitstream_mode_en_out     <= 1'b0;
			filter_bypass_en_out      <= 1'b0;
			mono_en_out               <= 1'b0;
			mono_source_pick_out      <= 1'b0;
			oversample_rate_sel_out   <= os_x64_type_val;
			deemph_rate_select_out    <= 2'h0;
			fir_perf_select_out       <= 2'h0;
			fir_rate_select_out       <= 2'h0;
			linear_zero_output_en_out <= 1'b1;
			bitstream_zero_output_out <= 2'h0;
		end else begin
			left_atten_out            <= att_l_reg;
			right_atten_out           <= att_r_reg;
			format_out                <= fmt_reg;
			analog_output_disable_out <= filt_reg[`BIT_ANALOG_DIS]; // RL3
			shared_pin_select_out     <= filt_reg[`BIT_PIN_SEL]; // RL4
			bypass_stereo_select_out  <= filt_reg[`BIT_BYP_STEREO]; // RL5
			rolloff_select_out        <= filt_reg[`BIT_ROLLOFF]; // RL6
			infinite_zero_mute_en_out <= filt_reg[`BIT_INF_MUTE]; // RL7
			phase_reverse_out         <= filt_reg[7];
			atten_rate_out            <= filt_reg[6:5];
			soft_system_reset_out     <= sys_reg[`BIT_SOFT_RST]; // RL8
			bitstream_mode_en_out     <= sys_reg[`BIT_BITSTREAM]; // RL9
			filter_bypass_en_out      <= sys_reg[`BIT_FILT_BYP]; // RL10
			mono_en_out               <= sys_reg[`BIT_MONO]; // RL11
			mono_source_pick_out      <= sys_reg[`BIT_MONO_SRC]; // RL11
			oversample_rate_sel_out   <= os_rate_type'(sys_reg[1:0]); // RL12
			// Shared fields steer the FIR only in bitstream mode
			deemph_rate_select_out    <= sys_reg[`BIT_BITSTREAM] ?
			                             2'h0 : fmt_reg[3:2];
			fir_perf_select_out       <= sys_reg[`BIT_BITSTREAM] ?
			                             fmt_reg[3:2] : 2'h0; // RL15
			fir_rate_select_out       <= sys_reg[`BIT_BITSTREAM] ?
			                             sys_reg[1:0] : 2'h0; // RL16
			linear_zero_output_en_out <= zout_reg[`BIT_LIN_ZERO]; // RL13
			bitstream_zero_output_out <= zout_reg[2:1]; // RL13
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// All writable storage, for checks that nothing moved
	logic [47:0] bank_all;
	assign bank_all = {att_l_reg, att_r_reg, fmt_reg,
	                   filt_reg, sys_reg, zout_reg};

	// Frame-level checks
	a_status_no_write: assert property (@(posedge mclk_in) // RL2
		disable iff (!rstn_in)
		(wr_hit && idx_reg >= `IDX_ZERO_STAT) |=> $stable(bank_all))
		else $error("status index accepted a write");
	a_unmapped_no_write: assert property (@(posedge mclk_in) // RL20
		disable iff (!rstn_in)
		(wr_hit && idx_reg < `IDX_ATT_LEFT) |=> $stable(bank_all))
		else $error("unmapped index accepted a write");
	a_write_no_drive: assert property (@(posedge mclk_in) // RL1
		disable iff (!rstn_in)
		(state_reg == st_data && !dir_reg) |-> !sdo_oe_out)
		else $error("write frame drove read data");
	a_write_once: assert property (@(posedge mclk_in) // RL18
		disable iff (!rstn_in) wr_hit |=> !wr_hit)
		else $error("write strobe repeated");
	a_oe_idle_low: assert property (@(posedge mclk_in) // RL18
		disable iff (!rstn_in)
		(state_reg == st_idle) |=> !sdo_oe_out)
		else $error("read drive kept outside a frame");
	a_reserved_sys_zero: assert property (@(posedge mclk_in) // RL19
		disable iff (!rstn_in) sys_reg[7] == 1'b0 && zout_reg[7:3] == 5'h00)
		else $error("reserved bits not zero");
	a_write_lands: assert property (@(posedge mclk_in) // RL18
		disable iff (!rstn_in)
		(wr_hit && idx_reg == `IDX_OUT_FILTER)
		|=> filt_reg == $past(word[7:0]))
		else $error("write data not stored");
	a_read_no_write: assert property (@(posedge mclk_in) // RL1
		disable iff (!rstn_in)
		(state_reg == st_data && dir_reg) |=> $stable(bank_all))
		else $error("read frame wrote a register");
	a_read_drive_en: assert property (@(posedge mclk_in) // RL18
		disable iff (!rstn_in)
		(state_reg == st_head && count == 5'(`HEAD_BITS) && sel_lvl)
		|=> sdo_oe_out == $past(word[7]))
		else $error("read drive not set after header");
	a_zero_flag_follow: assert property (@(posedge mclk_in) // RL14
		disable iff (!rstn_in)
		##1 zflag_reg == $past({right_zero_in, left_zero_in}))
		else $error("zero flags not sampled");
	// Decode checks
	a_fir_rate_map: assert property (@(posedge mclk_in) // RL16
		disable iff (!rstn_in)
		$past(sys_reg[`BIT_BITSTREAM])
		|-> fir_rate_select_out == $past(sys_reg[1:0]))
		else $error("fir rate not taken from rate field");
	a_unmapped_zero: assert property (@(posedge mclk_in) // RL20
		disable iff (!rstn_in)
		read_value(7'h00) == 8'h00 && read_value(7'h18) == 8'h00)
		else $error("unmapped index not zero");
endmodule

// *** tb/host_port_model.sv ***
`timescale 1ns/100ps
// ****************************************
// Host side of the serial control port
// ****************************************
module host_port_model (
	input  wire logic        mclk_in,
	input  wire logic        req_in,     // Start one frame
	input  wire logic [15:0] word_in,    // Word to shift out
	input  wire logic [4:0]  nbits_in,   // Bits sent, short frames too
	input  wire logic        sdo_in,
	input  wire logic        sdo_oe_in,
	output logic             sel_n_out,
	output logic             sclk_out,
	output logic             sdi_out,
	output logic             done_out,
	output logic [7:0]       rdata_out
);
	// Each bit clock phase, kept above the synchroniser minimum
	localparam int HALF = 8;
	int i;

	initial begin
		sel_n_out = 1'b1;
		sclk_out  = 1'b0;
		sdi_out   = 1'b0;
		done_out  = 1'b0;
		rdata_out = 8'h00;
	end

	// Bit clock stays high past the frame end, falls once, then stands still
	always begin
		@(posedge mclk_in);
		if (req_in && !done_out) begin
			sel_n_out <= 1'b0;
			repeat (HALF) @(posedge mclk_in);
			for (i = 0; i < int'(nbits_in); i++) begin
				sdi_out <= word_in[15 - i];
				repeat (HALF) @(posedge mclk_in);
				// Read bits are taken just before rises 9 to 16
				if (i >= 8 && sdo_oe_in === 1'b1) begin
					rdata_out <= {rdata_out[6:0], sdo_in};
				end
				sclk_out <= 1'b1;
				repeat (HALF) @(posedge mclk_in);
				if (i != int'(nbits_in) - 1) begin
					sclk_out <= 1'b0;
				end
			end
			sel_n_out <= 1'b1;
			// Released data line must not keep its last value
			sdi_out <= ~sdi_out;
			repeat (HALF) @(posedge mclk_in);
			sclk_out <= 1'b0;
			done_out <= 1'b1;
			while (req_in) @(posedge mclk_in);
			done_out <= 1'b0;
		end
	end
endmodule

// *** tb/audio_dac_mode_register_bank_bench.sv ***
`timescale 1ns/100ps
module audio_dac_mode_register_bank_bench;
	import dac_mode_pkg::*;
	// Arbitrary identity value
	localparam logic [4:0] ID_VAL = 5'h13;
	logic        mclk, rstn, req, lz, rz;
	logic        sel_n, sclk, sdi, sdo, sdo_oe, done;
	logic [15:0] word;
	logic [4:0]  nbits;
	logic [7:0]  rdata, d, latt, ratt, fmt;
	logic        ad, ps, bs, ro, im, ss, bm, fb, me, ms, lze, pr;
	logic [1:0]  dr, fp, fr, bz, ar;
	os_rate_type os;
	int          fails, samples_checked, i;
	logic [7:0]  rst_tab [6] = '{8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'h01};
	logic [7:0]  wr_tab  [8] = '{8'ha5, 8'h5a, 8'h3c, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff};
	logic [7:0]  rd_tab  [8] = '{8'ha5, 8'h5a, 8'h3c, 8'hff,
		8'h7f, 8'h07, 8'h01, {3'h0, ID_VAL}};
	os_rate_type os_tab  [3] = '{os_x64_type_val, os_x128_type_val,
		os_x32_type_val};

	always #5 mclk = ~mclk;

	dac_mode_regs #(.IDENTITY(ID_VAL)) dac_mode_regs_inst (
		.mclk_in(mclk), .rstn_in(rstn), .sel_n_in(sel_n),
		.sclk_in(sclk), .sdi_in(sdi), .left_zero_in(lz),
		.right_zero_in(rz), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
		.left_atten_out(latt), .right_atten_out(ratt),
		.format_out(fmt), .analog_output_disable_out(ad),
		.shared_pin_select_out(ps), .bypass_stereo_select_out(bs),
		.rolloff_select_out(ro), .infinite_zero_mute_en_out(im),
		.phase_reverse_out(pr), .atten_rate_out(ar),
		.soft_system_reset_out(ss), .bitstream_mode_en_out(bm),
		.filter_bypass_en_out(fb), .mono_en_out(me),
		.mono_source_pick_out(ms), .oversample_rate_sel_out(os),
		.deemph_rate_select_out(dr), .fir_perf_select_out(fp),
		.fir_rate_select_out(fr), .linear_zero_output_en_out(lze),
		.bitstream_zero_output_out(bz));

	host_port_model host_port_model_inst (
		.mclk_in(mclk), .req_in(req), .word_in(word),
		.nbits_in(nbits), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
		.sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi),
		.done_out(done), .rdata_out(rdata));

	// ****************************************
	// Reporting
	// ****************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Wait on the host handshake, bounded
	task automatic wait_done(input logic v);
		int k;
		k = 0;
		while (done !== v && k < 1000) begin
			@(posedge mclk);
			k++;
		end
		if (k >= 1000) begin
			fails++;
			summarize();
		end
	endtask

	// ****************************************
	// Port access
	// ****************************************
	task automatic frame(input logic [15:0] w, input logic [4:0] n);
		@(posedge mclk);
		word  <= w;
		nbits <= n;
		req   <= 1'b1;
		wait_done(1'b1);
		req <= 1'b0;
		wait_done(1'b0);
	endtask

	task automatic reg_write(input logic [6:0] idx, input logic [7:0] v);
		frame({1'b0, idx, v}, 5'd16);
	endtask

	task automatic reg_read(input logic [6:0] idx, output logic [7:0] v);
		frame({1'b1, idx, 8'h00}, 5'd16);
		v = rdata;
	endtask

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		req = 1'b0;
		word = 16'h0000;
		nbits = 5'd16;
		lz = 1'b0;
		rz = 1'b0;
		fails = 0;
		samples_checked = 0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4) @(posedge mclk);
		// Defaults of the writable bank and of its outputs
		for (i = 0; i < 6; i++) begin
			reg_read(7'h10 + 7'(i), d);
			check(d, rst_tab[i]);
		end
		check({3'h0, ad, ps, bs, ro, im}, 8'h00);
		check({2'h0, ss, bm, fb, me, ms, 1'b0}, 8'h00);
		check({6'h0, os}, 8'h00);
		check({5'h0, bz, lze}, 8'h01);
		check({5'h0, pr, ar}, 8'h00);
		// Full writes, masked reserved bits, read-only places
		lz <= 1'b1;
		for (i = 0; i < 8; i++) reg_write(7'h10 + 7'(i), wr_tab[i]);
		for (i = 0; i < 8; i++) begin
			reg_read(7'h10 + 7'(i), d);
			check(d, rd_tab[i]);
		end
		check(latt ^ ratt, 8'hff);
		check({3'h0, ad, ps, bs, ro, im}, 8'h1f);
		check({1'b0, ss, bm, fb, me, ms, 2'(os)}, 8'h7f);
		check({2'h0, fp, fr, dr}, 8'h3c);
		check({5'h0, bz, lze}, 8'h07);
		check({5'h0, pr, ar}, 8'h07);
		lz <= 1'b0;
		rz <= 1'b1;
		reg_read(7'h16, d);
		check(d, 8'h02);
		// Each rate code, with bitstream mode off again
		for (i = 0; i < 3; i++) begin
			reg_write(7'h14, {6'h0, os_tab[i]});
			check({6'h0, os}, {6'h0, os_tab[i]});
			check({2'h0, fp, fr, dr}, 8'h03);
		end
		// A frame one bit short must not store anything
		frame({1'b0, 7'h10, 8'h00}, 5'd15);
		reg_read(7'h10, d);
		check(d, 8'ha5);
		// Unmapped index stores nothing and reads zero
		reg_write(7'h05, 8'h77);
		reg_read(7'h05, d);
		check(d, 8'h00);
		reg_read(7'h11, d);
		check(d, 8'h5a);
		check(fmt, 8'h3c);
		summarize();
	end
endmodule
